// ===== hdl/dwsp_cfg.svh
`ifndef DWSP_CFG_SVH
`define DWSP_CFG_SVH

// word and field geometry of the serial shift register
`define DWSP_WORD_W       17
`define DWSP_CODE_W       8
`define DWSP_TAPS         256
// physical index of each field; index 0 is the entry end, index 16 the cascade end
`define DWSP_STACK_BIT    16
`define DWSP_POT1_MSB     15
`define DWSP_POT1_LSB     8
`define DWSP_POT0_MSB     7
`define DWSP_POT0_LSB     0
`define DWSP_CASCADE_BIT  16
// power-up values
`define DWSP_MID_CODE     8'h80
`define DWSP_STACK_RST    1'h0
`define DWSP_WORD_RST     17'h08080
`define DWSP_TAPS_RST     (256'h1 << 8'h80)
// timing: clock period and worst delay from shift to cascade output
`define DWSP_CLK_PERIOD_NS 50
`define DWSP_COUT_DELAY_NS 50

`endif

// ===== hdl/dwsp_pkg.sv
`include "dwsp_cfg.svh"
`default_nettype none

package dwsp_pkg;
  typedef logic [`DWSP_CODE_W-1:0] dwsp_code_t; // one wiper position code
  typedef logic [`DWSP_WORD_W-1:0] dwsp_word_t; // whole serial word
  typedef logic [`DWSP_TAPS-1:0]   dwsp_taps_t; // one-hot tap selection
endpackage : dwsp_pkg

`default_nettype wire

// ===== hdl/dwsp_serial_port.sv
`include "dwsp_cfg.svh"
`default_nettype none

// Summary of operation
// - each wiper sits on one of 256 taps
// - both codes and stack bit in 17-bit register
// - deselected port ignores clock and data
// - data sampled on rising serial clock edge
// - position 0 is the stack-select bit
// - positions 1-8 are pot one, MSB first
// - positions 9-16 are pot zero, MSB first
// - wipers written and read back by shifting
// - daisy-chain through cascade output supported
// - wipers load only when select falls
// - power-up wiper codes are mid-scale 0x80
// - cascade output always drives outgoing bit
module dwsp_serial_port (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 port_select,
  input  wire logic                 serial_clock,
  input  wire logic                 serial_data,
  output var  logic                 cascade_out,
  output var  dwsp_pkg::dwsp_taps_t wiper_zero_terminal,
  output var  dwsp_pkg::dwsp_taps_t wiper_one_terminal,
  output var  dwsp_pkg::dwsp_taps_t stacked_wiper_out,
  output var  dwsp_pkg::dwsp_code_t wiper_zero_code,
  output var  dwsp_pkg::dwsp_code_t wiper_one_code,
  output var  logic                 stack_select
);

  ////////////////////////////////////////////////////////////////////////////////
  // timing constants
  localparam int CLK_PERIOD_NS = `DWSP_CLK_PERIOD_NS; // system clock period
  localparam int COUT_DELAY_NS = `DWSP_COUT_DELAY_NS; // worst shift-to-cascade delay
  // longest time rounds down, never below one cycle
  localparam int COUT_CYC = (COUT_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 :
                            (COUT_DELAY_NS / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                 sclk_prev_r;  // serial clock one cycle ago
  logic                 sel_prev_r;   // port select one cycle ago
  logic                 sclk_rise;    // rising serial clock edge seen
  logic                 sel_fall;     // port select just dropped
  logic                 shift_en;     // shift this cycle
  dwsp_pkg::dwsp_word_t shift_r;      // the 17-bit serial word
  dwsp_pkg::dwsp_word_t shift_nxt;    // next serial word
  logic                 loaded_r;     // a deselect load has happened since reset

  ////////////////////////////////////////////////////////////////////////////////
  // edge detection on the pins, which are synchronous to clk
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_r <= 1'h0;
      sel_prev_r  <= 1'h0;
    end else begin
      sclk_prev_r <= serial_clock;
      sel_prev_r  <= port_select;
    end
  end

  assign sclk_rise = serial_clock & ~sclk_prev_r; // sample point of each bit
  assign sel_fall  = sel_prev_r & ~port_select;   // end of a transaction

  // shifting only while the port is selected
  assign shift_en = port_select & sclk_rise;

  ////////////////////////////////////////////////////////////////////////////////
  // next serial word: older bits move toward the cascade end, new bit at entry
  always_comb begin
    if (shift_en) begin
      shift_nxt = {shift_r[`DWSP_WORD_W-2:0], serial_data};
    end else begin
      shift_nxt = shift_r; // deselected or no edge: hold
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial word storage, kept for as long as power stays on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= `DWSP_WORD_RST; // matches the mid-scale wipers
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // the bit leaving the word is always on the cascade pin, selected or not;
  // with the pin looped back to the data input a full word circulates intact
  assign cascade_out = shift_r[`DWSP_CASCADE_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // wiper codes and stack select: loaded only on the deselect transition
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wiper_zero_code <= `DWSP_MID_CODE;
      wiper_one_code  <= `DWSP_MID_CODE;
      stack_select    <= `DWSP_STACK_RST;
    end else if (sel_fall) begin
      // first bit sent has reached the cascade end after a whole word
      stack_select    <= shift_r[`DWSP_STACK_BIT];
      wiper_one_code  <= shift_r[`DWSP_POT1_MSB:`DWSP_POT1_LSB];
      wiper_zero_code <= shift_r[`DWSP_POT0_MSB:`DWSP_POT0_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helper for the power-up check: set at the first load
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loaded_r <= 1'h0;
    end else if (sel_fall) begin
      loaded_r <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // tap decoders, one per potentiometer
  dwsp_tap_select u_tap_zero (
    .clk    (clk),
    .arst_n (arst_n),
    .code   (wiper_zero_code),
    .taps_r (wiper_zero_terminal)
  );

  dwsp_tap_select u_tap_one (
    .clk    (clk),
    .arst_n (arst_n),
    .code   (wiper_one_code),
    .taps_r (wiper_one_terminal)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // stacked output: stack bit 1 routes pot one, 0 routes pot zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stacked_wiper_out <= `DWSP_TAPS_RST;
    end else if (stack_select) begin
      stacked_wiper_out <= wiper_one_terminal;
    end else begin
      stacked_wiper_out <= wiper_zero_terminal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_hold_deselected;
    @(posedge clk) disable iff (!arst_n)
      !port_select |=> shift_r == $past(shift_r);
  endproperty
  a_hold_deselected: assert property (p_hold_deselected)
    else $error("word changed while deselected");

  property p_shift_in;
    @(posedge clk) disable iff (!arst_n)
      (port_select && serial_clock && !sclk_prev_r) |=>
        shift_r[0] == $past(serial_data) && shift_r[16:1] == $past(shift_r[15:0]);
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("bit not shifted in on rising edge");

  property p_no_edge_hold;
    @(posedge clk) disable iff (!arst_n)
      (serial_clock == sclk_prev_r) |=> $stable(shift_r);
  endproperty
  a_no_edge_hold: assert property (p_no_edge_hold)
    else $error("word moved without a rising edge");

  property p_load_fields;
    @(posedge clk) disable iff (!arst_n)
      (sel_prev_r && !port_select) |=>
        stack_select == $past(shift_r[16]) && wiper_one_code == $past(shift_r[15:8]);
  endproperty
  a_load_fields: assert property (p_load_fields)
    else $error("stack bit or pot one wrong after load");

  property p_load_pot0;
    @(posedge clk) disable iff (!arst_n)
      (sel_prev_r && !port_select) |=> wiper_zero_code == $past(shift_r[7:0]);
  endproperty
  a_load_pot0: assert property (p_load_pot0)
    else $error("pot zero wrong after load");

  property p_only_on_deselect;
    @(posedge clk) disable iff (!arst_n)
      !(sel_prev_r && !port_select) |=>
        $stable(wiper_zero_code) && $stable(wiper_one_code) && $stable(stack_select);
  endproperty
  a_only_on_deselect: assert property (p_only_on_deselect)
    else $error("wiper changed outside deselect");

  property p_power_up_mid;
    @(posedge clk) disable iff (!arst_n)
      !loaded_r |-> wiper_zero_code == 8'h80 && wiper_one_code == 8'h80;
  endproperty
  a_power_up_mid: assert property (p_power_up_mid)
    else $error("wiper not mid-scale before first load");

  property p_cascade_follows;
    @(posedge clk) disable iff (!arst_n)
      (port_select && serial_clock && !sclk_prev_r) |->
        ##[1:COUT_CYC] cascade_out == $past(shift_r[15], 1);
  endproperty
  a_cascade_follows: assert property (p_cascade_follows)
    else $error("cascade output late or wrong");

  property p_stacked_route;
    @(posedge clk) disable iff (!arst_n)
      1'b1 |=> stacked_wiper_out ==
        ($past(stack_select) ? $past(wiper_one_terminal) : $past(wiper_zero_terminal));
  endproperty
  a_stacked_route: assert property (p_stacked_route)
    else $error("stacked output routes wrong wiper");

  // main scenarios
  c_shift: cover property (@(posedge clk) disable iff (!arst_n) shift_en);
  c_load: cover property (@(posedge clk) disable iff (!arst_n) sel_fall);
  c_stack_one: cover property (@(posedge clk) disable iff (!arst_n) sel_fall ##1 stack_select);

endmodule : dwsp_serial_port

`default_nettype wire

// ===== hdl/dwsp_tap_select.sv
`include "dwsp_cfg.svh"
`default_nettype none

module dwsp_tap_select (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire dwsp_pkg::dwsp_code_t code,
  output var  dwsp_pkg::dwsp_taps_t taps_r
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode the position code onto exactly one of the taps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      taps_r <= `DWSP_TAPS_RST; // mid-scale tap at power-up
    end else begin
      taps_r <= dwsp_pkg::dwsp_taps_t'(1) << code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_tap_onehot;
    @(posedge clk) disable iff (!arst_n) $onehot(taps_r);
  endproperty
  a_tap_onehot: assert property (p_tap_onehot) else $error("wiper not on one tap");

  property p_tap_follows;
    @(posedge clk) disable iff (!arst_n) 1'b1 |=> taps_r[$past(code)];
  endproperty
  a_tap_follows: assert property (p_tap_follows) else $error("tap differs from code");

endmodule : dwsp_tap_select

`default_nettype wire

// ===== tb/dwsp_host.sv
`default_nettype none

// behavioural controller for the three-wire port; drives only at falling clk edges
module dwsp_host (
  input  wire logic clk,          // system clock
  input  wire logic cascade_out,  // bit leaving the device word
  output var  logic port_select,  // active-high port select
  output var  logic serial_clock, // serial shift clock
  output var  logic serial_data   // serial data to the device
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    port_select  = 1'b0;
    serial_clock = 1'b0;
    serial_data  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one bit: data set with the rising serial clock, clock low one cycle later
  task automatic shift_bit(input logic b);
    @(negedge clk);
    serial_data  = b;
    serial_clock = 1'b1;
    @(negedge clk);
    serial_clock = 1'b0;
  endtask

  // select, then n bits first-sent-first; loopback feeds cascade_out back in
  task automatic put_word(input logic [16:0] w, input int n, input logic loopback,
                          output logic [16:0] seen);
    seen = '0;
    @(negedge clk);
    port_select = 1'b1;
    for (int i = 0; i < n; i++) begin
      seen = {seen[15:0], cascade_out};
      shift_bit(loopback ? cascade_out : w[16-i]);
    end
  endtask

  // deselect; released data line shows the inverse of its last level
  task automatic release_port();
    @(negedge clk);
    port_select = 1'b0;
    serial_data = ~serial_data;
  endtask

  // clock and data activity while deselected; device must ignore it
  task automatic noise(input int n);
    repeat (n) begin
      @(negedge clk);
      serial_clock = ~serial_clock;
      serial_data  = ~serial_data;
    end
    @(negedge clk);
    serial_clock = 1'b0;
  endtask
endmodule // dwsp_host

`default_nettype wire

// ===== tb/test_dwsp_serial_port.sv
`default_nettype none

module test_dwsp_serial_port;
  timeunit 1ns;
  timeprecision 1ns;

  // one written word beside the outputs it must give after deselect
  typedef struct {
    logic [16:0] w;
    logic [7:0]  z;
    logic [7:0]  o;
    logic        s;
  } dwsp_row_s;

  logic                 clk = 1'b0; // system clock, driven only by the clock process
  logic                 arst_n, port_select, serial_clock, serial_data, cascade_out;
  dwsp_pkg::dwsp_taps_t wiper_zero_terminal, wiper_one_terminal, stacked_wiper_out;
  dwsp_pkg::dwsp_code_t wiper_zero_code, wiper_one_code;
  logic                 stack_select;
  int                   err_total, num_checks;
  logic [16:0]          seen;
  logic [16:0]          last; // word the device should now hold
  dwsp_row_s            rows [4] = '{'{17'h1FF00, 8'h00, 8'hFF, 1'h1},
                                     '{17'h000FF, 8'hFF, 8'h00, 1'h0},
                                     '{17'h1A53C, 8'h3C, 8'hA5, 1'h1},
                                     '{17'h00180, 8'h80, 8'h01, 1'h0}};

  ////////////////////////////////////////////////////////////////////////////////
  dwsp_serial_port dwsp_serial_port_i (.clk(clk), .arst_n(arst_n), .port_select(port_select),
    .serial_clock(serial_clock), .serial_data(serial_data), .cascade_out(cascade_out),
    .wiper_zero_terminal(wiper_zero_terminal), .wiper_one_terminal(wiper_one_terminal),
    .stacked_wiper_out(stacked_wiper_out), .wiper_zero_code(wiper_zero_code),
    .wiper_one_code(wiper_one_code), .stack_select(stack_select));
  dwsp_host dwsp_host_i (.clk(clk), .cascade_out(cascade_out), .port_select(port_select),
    .serial_clock(serial_clock), .serial_data(serial_data));

  // 50 ns clock
  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // codes, stack bit, one-hot taps and stacked output
  task automatic check_state(input logic [7:0] z, input logic [7:0] o, input logic s);
    chk("wiper_zero_code", z, wiper_zero_code);
    chk("wiper_one_code", o, wiper_one_code);
    chk("stack_select", s, stack_select);
    chk("wiper_zero_terminal", 256'h1 << z, wiper_zero_terminal);
    chk("wiper_one_terminal", 256'h1 << o, wiper_one_terminal);
    chk("stacked_wiper_out", 256'h1 << (s ? o : z), stacked_wiper_out);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    err_total = 0;
    num_checks = 0;
    last = 17'h08080;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    // power-up state
    check_state(8'h80, 8'h80, 1'b0);
    chk("cascade_out", 256'h0, cascade_out);
    // table of whole words
    foreach (rows[i]) begin
      dwsp_host_i.put_word(rows[i].w, 17, 1'b0, seen);
      chk("cascade_out", rows[i].w[16], cascade_out);
      chk("zero code before deselect", last[7:0], wiper_zero_code);
      dwsp_host_i.release_port();
      repeat (4) @(negedge clk);
      check_state(rows[i].z, rows[i].o, rows[i].s);
      last = rows[i].w;
    end
    // activity while deselected changes nothing
    dwsp_host_i.noise(9);
    repeat (4) @(negedge clk);
    check_state(last[7:0], last[15:8], last[16]);
    chk("cascade_out idle", last[16], cascade_out);
    // read back by circulating the word through cascade_out
    dwsp_host_i.put_word(17'h00000, 17, 1'b1, seen);
    chk("read back", last, seen);
    dwsp_host_i.release_port();
    repeat (4) @(negedge clk);
    check_state(last[7:0], last[15:8], last[16]);
    // short word of 9 bits shifts the old word on by 9
    dwsp_host_i.put_word(17'h1C3A5, 9, 1'b0, seen);
    dwsp_host_i.release_port();
    repeat (4) @(negedge clk);
    // the nine bits sent are word bits 16 down to 8: 1, then 8'hC3
    last = {last[7:0], 9'h1C3};
    check_state(last[7:0], last[15:8], last[16]);
    // reset in mid-transfer restores mid-scale
    dwsp_host_i.put_word(17'h1FFFF, 5, 1'b0, seen);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    check_state(8'h80, 8'h80, 1'b0);
    dwsp_host_i.release_port();
    repeat (4) @(negedge clk);
    check_state(8'h80, 8'h80, 1'b0);
    tally_and_finish();
  end
endmodule // test_dwsp_serial_port

`default_nettype wire
